// *** rtl/tcs_consts.svh ***
`ifndef TCS_CONSTS_SVH
`define TCS_CONSTS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TCS_CLK_HZ 25000000
`define TCS_CHECK_INTERVAL_MS 600
`define TCS_TICK_CYCLES ((`TCS_CLK_HZ / 1000) * `TCS_CHECK_INTERVAL_MS)
`define TCS_TWO_INPUT_CHECKS 3
`define TCS_ONE_INPUT_CHECKS 500

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TCS_CTRL_OFS 4'h0
`define TCS_STATUS_OFS 4'h4
`define TCS_IRQ_STAT_OFS 4'h8
`define TCS_IRQ_MASK_OFS 4'hc

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define TCS_CTRL_ENABLE 0
`define TCS_CTRL_TWO_INPUT 1
`define TCS_CTRL_COMMON_POT 2
`define TCS_CTRL_ALLOC_FIRST 3
`define TCS_CTRL_ALLOC_SECOND 4
`define TCS_CTRL_W 5
`define TCS_CTRL_RESET 5'h00

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define TCS_ST_FAIL 0
`define TCS_ST_MISMATCH 1
`define TCS_ST_BLOCKED 2
`define TCS_ST_ACTIVE 3
`define TCS_ST_HW_FAULT 4
`define TCS_ST_SENSE_FIRST 5
`define TCS_ST_SENSE_SECOND 6
`define TCS_ST_PICKED_UP 7
`define TCS_ST_COUNT_LSB 16

// ----------------------------------------------------------------
// Interrupt events
// ----------------------------------------------------------------
`define TCS_EV_ALARM_SET 0
`define TCS_EV_ALARM_CLR 1
`define TCS_EV_MISMATCH 2
`define TCS_EV_HW_FAULT 3
`define TCS_EV_W 4
`define TCS_IRQ_RESET 4'h0

`endif

// *** rtl/tcs_pkg.sv ***
package tcs_pkg;

  // Gray order along off -> watch -> alarm, blocked beside off
  typedef enum logic [1:0] {
    TCS_OFF = 2'b00,
    TCS_WATCH = 2'b01,
    TCS_ALARM = 2'b11,
    TCS_BLOCKED = 2'b10
  } tcs_state_type;

  typedef logic [31:0] tcs_word_type;

endpackage : tcs_pkg

// *** rtl/tcs_tick_div.sv ***
`timescale 1ns/100ps
`include "tcs_consts.svh"

module tcs_tick_div #(
  parameter int TICK_CYCLES = `TCS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Control
  input wire logic run_i,
  // Check strobe
  output logic tick_o
);

  localparam int CW = $clog2(TICK_CYCLES + 1);

  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("tcs_tick_div: TICK_CYCLES must be at least one");
  end

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic tick_reg;
  logic tick_next;

  // Restart on each activation so the first check lands one interval in
  always_comb begin
    cnt_next = cnt_reg;
    tick_next = 1'b0;
    if (!run_i) begin
      cnt_next = '0;
    end else if (cnt_reg == CW'(TICK_CYCLES - 1)) begin
      cnt_next = '0;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + CW'(1);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_o = tick_reg;

endmodule : tcs_tick_div

// *** rtl/tcs_top.sv ***
`timescale 1ns/100ps
`include "tcs_consts.svh"

module tcs_top
  import tcs_pkg::*;
#(
  parameter int TICK_CYCLES = `TCS_TICK_CYCLES,
  parameter int TWO_INPUT_CHECKS = `TCS_TWO_INPUT_CHECKS,
  parameter int ONE_INPUT_CHECKS = `TCS_ONE_INPUT_CHECKS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Avalon-MM slave
  input wire logic [3:0] av_address_i,
  input wire logic av_read_i,
  input wire logic av_write_i,
  input wire logic [3:0] av_byteenable_i,
  input wire tcs_pkg::tcs_word_type av_writedata_i,
  output tcs_pkg::tcs_word_type av_readdata_o,
  output logic av_waitrequest_o,
  // Trip circuit sense pins
  input wire logic first_sense_input_i,
  input wire logic second_sense_input_i,
  input wire logic supervision_block_input_i,
  // Protection pickup, same clock domain
  input wire logic device_picked_up_i,
  // Indications
  output logic trip_circuit_fail_o,
  output logic config_mismatch_alarm_o,
  output logic supervision_blocked_status_o,
  output logic supervision_active_o,
  output logic hardware_fault_o,
  output logic irq_o
);

  import tcs_pkg::*;

  localparam int CNT_W = $clog2(ONE_INPUT_CHECKS + 1);

  if (TWO_INPUT_CHECKS < 1 || ONE_INPUT_CHECKS < TWO_INPUT_CHECKS)
  begin : g_bad_counts
    $error("tcs_top: check counts must be positive and ordered");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;
  logic sense_a;
  logic sense_b;
  logic block_in;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
    end else begin
      pin_meta_reg <= {supervision_block_input_i, second_sense_input_i,
                       first_sense_input_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign sense_a = pin_sync_reg[0];
  assign sense_b = pin_sync_reg[1];
  assign block_in = pin_sync_reg[2];

  // ----------------------------------------------------------------
  // Register file and bus slave
  // ----------------------------------------------------------------
  logic [`TCS_CTRL_W-1:0] ctrl_reg;
  logic [`TCS_CTRL_W-1:0] ctrl_next;
  logic [`TCS_EV_W-1:0] irq_stat_reg;
  logic [`TCS_EV_W-1:0] irq_stat_next;
  logic [`TCS_EV_W-1:0] irq_mask_reg;
  logic [`TCS_EV_W-1:0] irq_mask_next;
  logic ack_reg;
  logic ack_next;
  tcs_word_type rdata_reg;
  tcs_word_type rdata_next;
  tcs_word_type status_word;
  logic [`TCS_EV_W-1:0] events;
  logic wr_take;

  // Byte address: upper bits pick the word, low bits must be zero
  function automatic logic hit(input logic [3:0] addr,
                               input logic [3:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  // One wait cycle lets read data come from a flop
  assign av_waitrequest_o = (av_read_i | av_write_i) & ~ack_reg;
  assign wr_take = av_write_i & ack_reg & av_byteenable_i[0];

  always_comb begin
    ctrl_next = ctrl_reg;
    irq_mask_next = irq_mask_reg;
    irq_stat_next = irq_stat_reg;
    ack_next = (av_read_i | av_write_i) & ~ack_reg;
    rdata_next = rdata_reg;
    if (wr_take && hit(av_address_i, `TCS_CTRL_OFS)) begin
      ctrl_next = av_writedata_i[`TCS_CTRL_W-1:0];
    end
    if (wr_take && hit(av_address_i, `TCS_IRQ_MASK_OFS)) begin
      irq_mask_next = av_writedata_i[`TCS_EV_W-1:0];
    end
    if (wr_take && hit(av_address_i, `TCS_IRQ_STAT_OFS)) begin
      irq_stat_next = irq_stat_reg & ~av_writedata_i[`TCS_EV_W-1:0];
    end
    // A new event beats a clear in the same cycle
    irq_stat_next = irq_stat_next | events;
    if (av_read_i && !ack_reg) begin
      rdata_next = '0;
      if (hit(av_address_i, `TCS_CTRL_OFS)) begin
        rdata_next[`TCS_CTRL_W-1:0] = ctrl_reg;
      end else if (hit(av_address_i, `TCS_STATUS_OFS)) begin
        rdata_next = status_word;
      end else if (hit(av_address_i, `TCS_IRQ_STAT_OFS)) begin
        rdata_next[`TCS_EV_W-1:0] = irq_stat_reg;
      end else if (hit(av_address_i, `TCS_IRQ_MASK_OFS)) begin
        rdata_next[`TCS_EV_W-1:0] = irq_mask_reg;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_reg <= `TCS_CTRL_RESET;
      irq_stat_reg <= `TCS_IRQ_RESET;
      irq_mask_reg <= `TCS_IRQ_RESET;
      ack_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign av_readdata_o = rdata_reg;
  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  logic enable;
  logic two_mode;
  logic mismatch;
  logic abnormal;
  logic both_high;
  logic run;
  logic tick;
  logic [CNT_W-1:0] need_last;

  assign enable = ctrl_reg[`TCS_CTRL_ENABLE];
  assign two_mode = ctrl_reg[`TCS_CTRL_TWO_INPUT];
  // Two inputs need both allocated, one input needs only the first
  assign mismatch = enable & (two_mode ?
      ~(ctrl_reg[`TCS_CTRL_ALLOC_FIRST] & ctrl_reg[`TCS_CTRL_ALLOC_SECOND]) :
      ~(ctrl_reg[`TCS_CTRL_ALLOC_FIRST] & ~ctrl_reg[`TCS_CTRL_ALLOC_SECOND]));
  assign abnormal = two_mode ? (~sense_a & ~sense_b) : ~sense_a;
  assign both_high = two_mode & ctrl_reg[`TCS_CTRL_COMMON_POT] &
                     sense_a & sense_b;
  assign run = enable & ~mismatch & ~block_in;
  assign need_last = two_mode ? CNT_W'(TWO_INPUT_CHECKS - 1) :
                                CNT_W'(ONE_INPUT_CHECKS - 1);

  tcs_tick_div #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .run_i(run),
    .tick_o(tick)
  );

  // ----------------------------------------------------------------
  // Supervision state machine
  // ----------------------------------------------------------------
  tcs_state_type state_reg;
  tcs_state_type state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic mismatch_reg;
  logic hw_fault_reg;
  logic hw_fault_next;
  logic check;

  // Pickup skips the check without losing progress of the count
  assign check = tick & ~device_picked_up_i;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    hw_fault_next = hw_fault_reg;
    case (state_reg)
      TCS_OFF, TCS_BLOCKED: begin
        cnt_next = '0;
        hw_fault_next = 1'b0;
        if (run) begin
          state_next = TCS_WATCH;
        end else if (enable && !mismatch) begin
          state_next = TCS_BLOCKED;
        end else begin
          state_next = TCS_OFF;
        end
      end
      TCS_WATCH, TCS_ALARM: begin
        if (!run) begin
          cnt_next = '0;
          hw_fault_next = 1'b0;
          state_next = (enable && !mismatch) ? TCS_BLOCKED : TCS_OFF;
        end else if (check) begin
          hw_fault_next = both_high;
          if (abnormal == (state_reg == TCS_ALARM)) begin
            cnt_next = '0;
          end else if (cnt_reg >= need_last) begin
            cnt_next = '0;
            state_next = (state_reg == TCS_ALARM) ? TCS_WATCH :
                                                    TCS_ALARM;
          end else begin
            cnt_next = cnt_reg + CNT_W'(1);
          end
        end
      end
      default: begin
        state_next = TCS_OFF;
        cnt_next = '0;
        hw_fault_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= TCS_OFF;
      cnt_reg <= '0;
      hw_fault_reg <= 1'b0;
      mismatch_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      hw_fault_reg <= hw_fault_next;
      mismatch_reg <= mismatch;
    end
  end

  assign trip_circuit_fail_o = (state_reg == TCS_ALARM);
  assign config_mismatch_alarm_o = mismatch_reg;
  assign supervision_blocked_status_o = (state_reg == TCS_BLOCKED);
  assign supervision_active_o = (state_reg == TCS_WATCH) ||
                                (state_reg == TCS_ALARM);
  assign hardware_fault_o = hw_fault_reg;

  assign events[`TCS_EV_ALARM_SET] = (state_next == TCS_ALARM) &&
                                     (state_reg != TCS_ALARM);
  assign events[`TCS_EV_ALARM_CLR] = (state_next != TCS_ALARM) &&
                                     (state_reg == TCS_ALARM);
  assign events[`TCS_EV_MISMATCH] = mismatch & ~mismatch_reg;
  assign events[`TCS_EV_HW_FAULT] = hw_fault_next & ~hw_fault_reg;

  always_comb begin
    status_word = '0;
    status_word[`TCS_ST_FAIL] = trip_circuit_fail_o;
    status_word[`TCS_ST_MISMATCH] = mismatch_reg;
    status_word[`TCS_ST_BLOCKED] = supervision_blocked_status_o;
    status_word[`TCS_ST_ACTIVE] = supervision_active_o;
    status_word[`TCS_ST_HW_FAULT] = hw_fault_reg;
    status_word[`TCS_ST_SENSE_FIRST] = sense_a;
    status_word[`TCS_ST_SENSE_SECOND] = sense_b;
    status_word[`TCS_ST_PICKED_UP] = device_picked_up_i;
    status_word[`TCS_ST_COUNT_LSB +: CNT_W] = cnt_reg;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_bus_one_wait: assert property (
    ((av_read_i || av_write_i) && av_waitrequest_o) |=>
      (!av_waitrequest_o || !(av_read_i || av_write_i)))
    else $error("bus answer took more than one wait cycle");
  a_mismatch_flag: assert property (
    (enable && two_mode && !ctrl_reg[`TCS_CTRL_ALLOC_SECOND]) |=>
      config_mismatch_alarm_o)
    else $error("mismatch alarm missing in two input mode");
  // Reset holds the flops at zero, so skip the edges whose history
  // reaches back into reset
  a_sense_sync: assert property (
    $past(reset_n_i, 3) |->
      (sense_a == $past(first_sense_input_i, 2)))
    else $error("sense input not passed through two flops");
  a_check_on_tick: assert property (
    ($changed(cnt_reg) && supervision_active_o && $past(run)) |->
      $past(tick))
    else $error("count moved without a check tick");
  a_alarm_raise: assert property (
    $rose(trip_circuit_fail_o) |->
      ($past(cnt_reg) == $past(need_last)) && $past(abnormal) &&
      $past(check))
    else $error("alarm raised without the full abnormal count");
  a_alarm_clear: assert property (
    ($fell(trip_circuit_fail_o) && supervision_active_o) |->
      ($past(cnt_reg) == $past(need_last)) && !$past(abnormal))
    else $error("alarm cleared without the full normal count");
  a_two_count: assert property (
    (two_mode && supervision_active_o) |-> (cnt_reg <= CNT_W'(2)))
    else $error("two input count exceeds three checks");
  a_hw_fault: assert property (
    (tick && run && !device_picked_up_i && both_high &&
     supervision_active_o) |=> hardware_fault_o)
    else $error("hardware fault not flagged on both high");
  a_pickup_hold: assert property (
    (device_picked_up_i && run && supervision_active_o) |=>
      ($stable(cnt_reg) && $stable(trip_circuit_fail_o)))
    else $error("supervision acted while picked up");
  a_block_status: assert property (
    (block_in && enable && !mismatch) |=>
      supervision_blocked_status_o && !trip_circuit_fail_o)
    else $error("block input not reported");
  a_off_clears: assert property (
    !run |=> (cnt_reg == '0) && !trip_circuit_fail_o)
    else $error("counter or alarm survived off or block");
  a_irq_alarm: assert property (
    $rose(trip_circuit_fail_o) |-> irq_stat_reg[`TCS_EV_ALARM_SET])
    else $error("alarm event not recorded");

  c_alarm_raised: cover property ($rose(trip_circuit_fail_o));
  c_alarm_cleared: cover property (
    $fell(trip_circuit_fail_o) && supervision_active_o);
  c_blocked: cover property ($rose(supervision_blocked_status_o));
  c_irq: cover property ($rose(irq_o));

endmodule : tcs_top

// *** tb/tcs_trip_circuit_model.sv ***
`timescale 1ns/100ps

// ----------------------------------------------------------------
// External trip circuit: relay contact, breaker contacts, resistor
// ----------------------------------------------------------------
module tcs_trip_circuit_model (
  // Circuit state
  input wire logic trip_closed_i,
  input wire logic breaker_open_i,
  input wire logic circuit_ok_i,
  // Defective input that reads energized whatever the contacts show
  input wire logic bi_fault_i,
  // Sense lines
  output logic first_sense_input_o,
  output logic second_sense_input_o
);
  // A closed relay contact shorts the first input; the second input
  // sees breaker_aux_contact_b, closed while the breaker is open.
  // A broken circuit or lost voltage leaves both inputs low.
  assign first_sense_input_o = circuit_ok_i &
    (~trip_closed_i | bi_fault_i);
  assign second_sense_input_o = circuit_ok_i &
    (breaker_open_i | bi_fault_i);
endmodule : tcs_trip_circuit_model

// *** tb/testbench.sv ***
`timescale 1ns/100ps
`include "tcs_consts.svh"

module testbench;
  import tcs_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int T = 10;
  localparam int N2 = 3;
  localparam int N1 = 5;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [3:0] av_address_i = 4'h0;
  logic av_read_i = 1'b0;
  logic av_write_i = 1'b0;
  logic [3:0] av_byteenable_i = 4'hf;
  tcs_word_type av_writedata_i = 32'h0;
  tcs_word_type av_readdata_o;
  logic av_waitrequest_o;
  logic s1, s2;
  logic trip_closed = 1'b0;
  logic breaker_open = 1'b0;
  logic circuit_ok = 1'b1;
  logic bi_fault = 1'b0;
  logic block = 1'b0;
  logic pickup = 1'b0;
  logic fail_o, mism_o, blk_o, act_o, hw_o, irq_o;
  int n_fail = 0;
  int n_tests = 0;

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  tcs_trip_circuit_model partner (
    .trip_closed_i(trip_closed),
    .breaker_open_i(breaker_open),
    .circuit_ok_i(circuit_ok),
    .bi_fault_i(bi_fault),
    .first_sense_input_o(s1),
    .second_sense_input_o(s2)
  );

  tcs_top #(.TICK_CYCLES(T), .TWO_INPUT_CHECKS(N2),
    .ONE_INPUT_CHECKS(N1)) dut (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .av_address_i(av_address_i),
    .av_read_i(av_read_i),
    .av_write_i(av_write_i),
    .av_byteenable_i(av_byteenable_i),
    .av_writedata_i(av_writedata_i),
    .av_readdata_o(av_readdata_o),
    .av_waitrequest_o(av_waitrequest_o),
    .first_sense_input_i(s1),
    .second_sense_input_i(s2),
    .supervision_block_input_i(block),
    .device_picked_up_i(pickup),
    .trip_circuit_fail_o(fail_o),
    .config_mismatch_alarm_o(mism_o),
    .supervision_blocked_status_o(blk_o),
    .supervision_active_o(act_o),
    .hardware_fault_o(hw_o),
    .irq_o(irq_o)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    if (n_fail == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input tcs_word_type got, input tcs_word_type exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a,
    input tcs_word_type d, output tcs_word_type q);
    int i;
    av_address_i <= a;
    av_writedata_i <= d;
    av_write_i <= wr;
    av_read_i <= ~wr;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_i);
      if (av_waitrequest_o === 1'b0) break;
    end
    q = av_readdata_o;
    av_write_i <= 1'b0;
    av_read_i <= 1'b0;
    if (i == 50) begin
      n_fail++;
      end_sim();
    end
    // Let an edge pass so a following call never re-raises in this step
    @(posedge clk_i);
  endtask : bus

  task automatic wr(input logic [3:0] a, input tcs_word_type d);
    tcs_word_type q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [3:0] a, input tcs_word_type exp);
    tcs_word_type q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rd_chk

  function automatic logic pick(input int sel);
    case (sel)
      0: return fail_o;
      1: return mism_o;
      2: return blk_o;
      default: return hw_o;
    endcase
  endfunction : pick

  // Waits for an indication to reach lvl; its arrival must fall in
  // [lo, hi] cycles, which pins down the number of checks taken.
  task automatic wait_out(input int sel, input logic lvl,
    input int lo, input int hi);
    int i;
    for (i = 0; i <= hi; i++) begin
      // Read at the edge: the value that stood through the last cycle
      @(posedge clk_i);
      if (pick(sel) === lvl) break;
    end
    if (i > hi) begin
      n_fail++;
      end_sim();
    end
    chk(32'(i >= lo), 32'h1);
  endtask : wait_out

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : idle

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk({fail_o, mism_o, blk_o, act_o, hw_o, irq_o}, 32'h0);
    rd_chk(`TCS_CTRL_OFS, 32'h0);
    rd_chk(`TCS_IRQ_STAT_OFS, 32'h0);
    rd_chk(`TCS_IRQ_MASK_OFS, 32'h0);
    wr(4'h2, 32'hffffffff);
    rd_chk(4'h2, 32'h0);
    av_byteenable_i <= 4'he;
    wr(`TCS_CTRL_OFS, 32'h1b);
    av_byteenable_i <= 4'hf;
    rd_chk(`TCS_CTRL_OFS, 32'h0);
  endtask : t_reset

  task automatic t_mismatch;
    wr(`TCS_CTRL_OFS, 32'h0b);
    wait_out(1, 1'b1, 0, 6);
    wr(`TCS_CTRL_OFS, 32'h19);
    idle(4);
    chk(mism_o, 1'b1);
    wr(`TCS_CTRL_OFS, 32'h1b);
    wait_out(1, 1'b0, 0, 6);
    wr(`TCS_CTRL_OFS, 32'h0);
    wr(`TCS_IRQ_STAT_OFS, 32'hf);
  endtask : t_mismatch

  task automatic t_two_input;
    trip_closed <= 1'b1;
    wr(`TCS_IRQ_MASK_OFS, 32'hf);
    wr(`TCS_CTRL_OFS, 32'h1b);
    idle(3);
    chk(act_o, 1'b1);
    wait_out(0, 1'b1, 3 * T - 5, 3 * T + 8);
    chk(irq_o, 1'b1);
    rd_chk(`TCS_IRQ_STAT_OFS, 32'h1);
    wr(`TCS_IRQ_MASK_OFS, 32'he);
    idle(1);
    chk(irq_o, 1'b0);
    wr(`TCS_IRQ_STAT_OFS, 32'h1);
    rd_chk(`TCS_IRQ_STAT_OFS, 32'h0);
    wr(`TCS_IRQ_MASK_OFS, 32'hf);
    trip_closed <= 1'b0;
    wait_out(0, 1'b0, 2 * T, 3 * T + 6);
    rd_chk(`TCS_IRQ_STAT_OFS, 32'h2);
    wr(`TCS_IRQ_STAT_OFS, 32'h2);
    chk(irq_o, 1'b0);
    // Two abnormal checks only: a transition, no alarm
    trip_closed <= 1'b1;
    idle(2 * T);
    trip_closed <= 1'b0;
    idle(4 * T);
    chk(fail_o, 1'b0);
    wr(`TCS_CTRL_OFS, 32'h0);
  endtask : t_two_input

  task automatic t_hw_fault;
    bi_fault <= 1'b1;
    wr(`TCS_CTRL_OFS, 32'h1f);
    wait_out(3, 1'b1, 0, T + 8);
    idle(4 * T);
    chk(fail_o, 1'b0);
    rd_chk(`TCS_STATUS_OFS, 32'h78);
    rd_chk(`TCS_IRQ_STAT_OFS, 32'h8);
    wr(`TCS_IRQ_STAT_OFS, 32'hf);
    bi_fault <= 1'b0;
    wr(`TCS_CTRL_OFS, 32'h0);
  endtask : t_hw_fault

  task automatic t_one_input;
    circuit_ok <= 1'b0;
    pickup <= 1'b1;
    wr(`TCS_CTRL_OFS, 32'h09);
    idle(8 * T);
    chk(fail_o, 1'b0);
    pickup <= 1'b0;
    wait_out(0, 1'b1, (N1 - 1) * T, N1 * T + 6);
    // Block suspends supervision and drops the alarm
    block <= 1'b1;
    wait_out(2, 1'b1, 0, 6);
    chk({fail_o, act_o}, 2'b00);
    block <= 1'b0;
    wait_out(2, 1'b0, 0, 6);
    idle(2);
    chk(act_o, 1'b1);
    idle((N1 - 1) * T - 4);
    chk(fail_o, 1'b0);
    wr(`TCS_CTRL_OFS, 32'h0);
    idle(2);
    chk({fail_o, act_o}, 2'b00);
    circuit_ok <= 1'b1;
  endtask : t_one_input

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    t_reset();
    t_mismatch();
    t_two_input();
    t_hw_fault();
    t_one_input();
    end_sim();
  end
endmodule : testbench
